// ==== logic/ambient_light_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the ambient light block
`ifndef AMBIENT_LIGHT_CFG_SVH
`define AMBIENT_LIGHT_CFG_SVH

`define ADDR_SENSOR_CONFIG_A 8'h0E
`define ADDR_SENSOR_CONFIG_B 8'h0F
`define ADDR_SENSOR_CONFIG_C 8'h10
`define ADDR_AMBIENT_READING 8'h11
`define ADDR_LEVEL_FIRST 8'h12
`define ADDR_LEVEL_LAST 8'h21
`define ADDR_SUB_THRESHOLDS 8'h22
`define ADDR_SUB_CONTROL 8'h23

`define CFG_A_SENSOR_ENABLE 0
`define CFG_A_SENSOR_LINEARITY 1
`define CFG_A_OUTPUT_CURVE 2
`define CFG_A_GAIN_MODE_SELECT 3
`define CFG_A_RESET 8'h00

`define CFG_B_BIAS_SELECT_LSB 0
`define CFG_B_RESET 8'h00

`define CFG_C_GAIN_CORR_LSB 0
`define CFG_C_POLL_PERIOD_LSB 4
`define CFG_C_POLL_MODE 6
`define CFG_C_POLL_REQUEST 7
`define CFG_C_RESET 8'h00

`define SUB_HIGH_LSB 4
`define SUB_LOW_LSB 0
`define SUB_THRESHOLDS_RESET 8'hC3
`define SUB_CTRL_ENABLE 0
`define SUB_CTRL_RESPONSE_TYPE 1
`define SUB_CONTROL_RESET 8'h00

// Level 15 first, level 0 last
`define LEVEL_RESET_VALUES {8'h72, 8'h5C, 8'h4A, 8'h3C, 8'h30, 8'h27, 8'h1F, 8'h19, \
  8'h14, 8'h10, 8'h0D, 8'h0A, 8'h08, 8'h06, 8'h05, 8'h04}

`define SUB_FLOOR_LEVEL 8'h00
`define SUB_CEILING_LEVEL 8'h2C

// Automatic gain switch points on the raw code
`define AUTO_GAIN_DIM_LIMIT 8'h10
`define AUTO_GAIN_BRIGHT_LIMIT 8'hF0
`define HIGH_GAIN_SHIFT 3

// One polling unit is 0.5 s
`define POLL_UNIT_MS 500
`define MCLK_KHZ 25000
`define POLL_UNIT_CYCLES (`POLL_UNIT_MS * `MCLK_KHZ)

`endif

// ==== logic/ambient_light_pkg.sv ====
// Types shared by the ambient light block
package ambient_light_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [3:0] amb_level_t;
  typedef logic [1:0] poll_period_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONVERT = 3'b010,
    ST_UPDATE = 3'b100
  } meas_state_t;
endpackage : ambient_light_pkg

// ==== logic/poll_timer.sv ====
// Polling interval timer, one tick at the end of every selected interval
`timescale 1ns/1ns
`include "ambient_light_cfg.svh"
module poll_timer #(
  parameter int UNIT_CYCLES = `POLL_UNIT_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic run,
  input wire ambient_light_pkg::poll_period_t period,
  output logic tick
);
  import ambient_light_pkg::*;

  logic [31:0] cycle_ff;
  logic [2:0] unit_ff;
  logic unit_end;
  logic [2:0] units_needed;

  assign unit_end = (cycle_ff == 32'(UNIT_CYCLES - 1));
  assign units_needed = {1'b0, period} + 3'h1;

  always_ff @(posedge mclk) begin
    if (reset || !run) begin
      cycle_ff <= 32'h0000_0000;
    end else if (unit_end) begin
      cycle_ff <= 32'h0000_0000;
    end else begin
      cycle_ff <= cycle_ff + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || !run) begin
      unit_ff <= 3'h0;
      tick <= 1'b0;
    end else if (unit_end && (unit_ff + 3'h1 >= units_needed)) begin
      unit_ff <= 3'h0;
      tick <= 1'b1;
    end else begin
      if (unit_end) begin
        unit_ff <= unit_ff + 3'h1;
      end
      tick <= 1'b0;
    end
  end
endmodule : poll_timer

// ==== logic/ambient_light_control.sv ====
// Ambient light sensor management: gain, bias, polling, level lookup and Sub response
`timescale 1ns/1ns
`include "ambient_light_cfg.svh"
module ambient_light_control #(
  parameter int POLL_UNIT_CYCLES = `POLL_UNIT_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire ambient_light_pkg::reg_byte_t reg_addr,
  input wire ambient_light_pkg::reg_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output ambient_light_pkg::reg_byte_t reg_rdata,
  input wire ambient_light_pkg::reg_byte_t adc_raw,
  input wire logic adc_done,
  output logic conv_start,
  output logic gain_res_high,
  output logic sensor_bias_output_en,
  output logic [1:0] bias_select,
  output logic sensor_linearity,
  output logic output_curve,
  output ambient_light_pkg::reg_byte_t main_level,
  output ambient_light_pkg::reg_byte_t sub_level,
  output logic sub_active,
  input wire logic fade_enable,
  input wire logic fade_initiate,
  output logic sub_fade_enable,
  output logic sub_fade_initiate
);
  import ambient_light_pkg::*;

  localparam logic [127:0] LEVEL_RESET = `LEVEL_RESET_VALUES;

  reg_byte_t cfg_a_ff;
  reg_byte_t cfg_b_ff;
  reg_byte_t cfg_c_ff;
  reg_byte_t sub_thr_ff;
  reg_byte_t sub_ctrl_ff;
  reg_byte_t level_ff [16];
  logic [4:0] ambient_ff;
  logic poll_req_ff;
  meas_state_t state_ff;
  meas_state_t nxt_state;
  logic poll_tick;
  logic auto_poll;
  logic start_meas;
  reg_byte_t raw_scaled;
  logic signed [13:0] corr_sum;
  reg_byte_t corrected;
  logic [4:0] nxt_ambient;
  amb_level_t amb_high;
  amb_level_t amb_low;
  reg_byte_t rd_mux;
  logic [4:0] lvl_index;

  assign auto_poll = !cfg_c_ff[`CFG_C_POLL_MODE];
  assign amb_high = sub_thr_ff[`SUB_HIGH_LSB +: 4];
  assign amb_low = sub_thr_ff[`SUB_LOW_LSB +: 4];

  poll_timer #(
    .UNIT_CYCLES(POLL_UNIT_CYCLES)
  ) u_poll_timer (
    .mclk(mclk),
    .reset(reset),
    .run(cfg_a_ff[`CFG_A_SENSOR_ENABLE] && auto_poll),
    .period(cfg_c_ff[`CFG_C_POLL_PERIOD_LSB +: 2]),
    .tick(poll_tick)
  );

  // Register writes
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg_a_ff <= `CFG_A_RESET;
      cfg_b_ff <= `CFG_B_RESET;
      cfg_c_ff <= `CFG_C_RESET;
      sub_thr_ff <= `SUB_THRESHOLDS_RESET;
      sub_ctrl_ff <= `SUB_CONTROL_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADDR_SENSOR_CONFIG_A: cfg_a_ff <= reg_wdata;
        `ADDR_SENSOR_CONFIG_B: cfg_b_ff <= reg_wdata;
        `ADDR_SENSOR_CONFIG_C: cfg_c_ff <= {1'b0, reg_wdata[6:0]};
        `ADDR_SUB_THRESHOLDS: sub_thr_ff <= reg_wdata;
        `ADDR_SUB_CONTROL: sub_ctrl_ff <= reg_wdata;
        default: cfg_a_ff <= cfg_a_ff;
      endcase
    end
  end

  // Level table
  assign lvl_index = 5'(reg_addr - `ADDR_LEVEL_FIRST);
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        level_ff[i] <= LEVEL_RESET[i*8 +: 8];
      end
    end else if (reg_wr && reg_addr >= `ADDR_LEVEL_FIRST && reg_addr <= `ADDR_LEVEL_LAST) begin
      level_ff[lvl_index[3:0]] <= reg_wdata;
    end
  end

  // Manual poll request, consumed when a measurement starts
  always_ff @(posedge mclk) begin
    if (reset) begin
      poll_req_ff <= 1'b0;
    end else if (reg_wr && reg_addr == `ADDR_SENSOR_CONFIG_C && reg_wdata[`CFG_C_POLL_REQUEST]) begin
      poll_req_ff <= 1'b1;
    end else if (start_meas) begin
      poll_req_ff <= 1'b0;
    end
  end

  assign start_meas = (state_ff == ST_IDLE) && cfg_a_ff[`CFG_A_SENSOR_ENABLE]
    && (auto_poll ? poll_tick : poll_req_ff);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (start_meas) nxt_state = ST_CONVERT;
      ST_CONVERT: if (adc_done) nxt_state = ST_UPDATE;
      ST_UPDATE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      conv_start <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      conv_start <= start_meas;
    end
  end

  // Gain correction: corrected = raw * (16 + g) / 16
  always_comb begin
    raw_scaled = gain_res_high ? (adc_raw >> `HIGH_GAIN_SHIFT) : adc_raw;
    corr_sum = $signed({2'b00, raw_scaled, 4'h0})
      + $signed({6'h00, raw_scaled}) * $signed({{10{cfg_c_ff[3]}}, cfg_c_ff[3:0]});
    corrected = (corr_sum[13:12] != 2'b00) ? 8'hFF : corr_sum[11:4];
    nxt_ambient = {cfg_c_ff[`CFG_C_GAIN_CORR_LSB + 3], corrected[7:4]};
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ambient_ff <= 5'h00;
      main_level <= 8'h00;
    end else if (state_ff == ST_CONVERT && adc_done) begin
      ambient_ff <= nxt_ambient;
      main_level <= level_ff[nxt_ambient[3:0]];
    end
  end

  // Gain resistor choice for the next measurement
  always_ff @(posedge mclk) begin
    if (reset) begin
      gain_res_high <= 1'b0;
    end else if (cfg_a_ff[`CFG_A_GAIN_MODE_SELECT]) begin
      gain_res_high <= 1'b0;
    end else if (state_ff == ST_CONVERT && adc_done) begin
      if (!gain_res_high && adc_raw < `AUTO_GAIN_DIM_LIMIT) begin
        gain_res_high <= 1'b1;
      end else if (gain_res_high && adc_raw >= `AUTO_GAIN_BRIGHT_LIMIT) begin
        gain_res_high <= 1'b0;
      end
    end
  end

  // Sub group response
  always_ff @(posedge mclk) begin
    if (reset) begin
      sub_level <= `SUB_FLOOR_LEVEL;
      sub_active <= 1'b0;
    end else begin
      sub_active <= sub_ctrl_ff[`SUB_CTRL_ENABLE];
      if (sub_ctrl_ff[`SUB_CTRL_ENABLE] && state_ff == ST_CONVERT && adc_done) begin
        if (nxt_ambient[3:0] > amb_high) begin
          sub_level <= sub_ctrl_ff[`SUB_CTRL_RESPONSE_TYPE] ?
            `SUB_CEILING_LEVEL : `SUB_FLOOR_LEVEL;
        end else if (nxt_ambient[3:0] < amb_low) begin
          sub_level <= sub_ctrl_ff[`SUB_CTRL_RESPONSE_TYPE] ?
            `SUB_FLOOR_LEVEL : `SUB_CEILING_LEVEL;
        end
      end
    end
  end

  // Fade masking and static outputs
  always_ff @(posedge mclk) begin
    if (reset) begin
      sub_fade_enable <= 1'b0;
      sub_fade_initiate <= 1'b0;
      sensor_bias_output_en <= 1'b0;
      bias_select <= 2'b00;
      sensor_linearity <= 1'b0;
      output_curve <= 1'b0;
    end else begin
      sub_fade_enable <= fade_enable && !sub_ctrl_ff[`SUB_CTRL_ENABLE];
      sub_fade_initiate <= fade_initiate && !sub_ctrl_ff[`SUB_CTRL_ENABLE];
      sensor_bias_output_en <= cfg_a_ff[`CFG_A_SENSOR_ENABLE];
      bias_select <= cfg_b_ff[`CFG_B_BIAS_SELECT_LSB +: 2];
      sensor_linearity <= cfg_a_ff[`CFG_A_SENSOR_LINEARITY];
      output_curve <= cfg_a_ff[`CFG_A_OUTPUT_CURVE];
    end
  end

  // Register reads
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      `ADDR_SENSOR_CONFIG_A: rd_mux = cfg_a_ff;
      `ADDR_SENSOR_CONFIG_B: rd_mux = cfg_b_ff;
      `ADDR_SENSOR_CONFIG_C: rd_mux = cfg_c_ff;
      `ADDR_AMBIENT_READING: rd_mux = {3'b000, ambient_ff};
      `ADDR_SUB_THRESHOLDS: rd_mux = sub_thr_ff;
      `ADDR_SUB_CONTROL: rd_mux = sub_ctrl_ff;
      default: begin
        if (reg_addr >= `ADDR_LEVEL_FIRST && reg_addr <= `ADDR_LEVEL_LAST) begin
          rd_mux = level_ff[lvl_index[3:0]];
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence meas_done_s;
    state_ff == ST_CONVERT && adc_done;
  endsequence

  sequence started_s;
    conv_start ##1 state_ff == ST_CONVERT;
  endsequence

  auto_poll_start_a: assert property (
    poll_tick && auto_poll && state_ff == ST_IDLE && cfg_a_ff[0] |=> started_s)
    else $error("automatic poll tick did not start a measurement");

  manual_hold_a: assert property (
    !auto_poll && !poll_req_ff && state_ff == ST_IDLE |=> !conv_start)
    else $error("measurement started in manual mode without a request");

  low_gain_fixed_a: assert property (
    cfg_a_ff[3] ##1 cfg_a_ff[3] |-> !gain_res_high)
    else $error("high gain resistor used in manual gain mode");

  level_select_a: assert property (
    meas_done_s ##1 !$past(reg_wr) |-> main_level == level_ff[ambient_ff[3:0]])
    else $error("main level does not match the ambient reading");

  sub_dim_type_a: assert property (
    meas_done_s and (sub_ctrl_ff[1:0] == 2'b01 && nxt_ambient[3:0] > amb_high)
    |=> sub_level == `SUB_FLOOR_LEVEL)
    else $error("dimming response did not go to floor");

  sub_bright_type_a: assert property (
    meas_done_s and (sub_ctrl_ff[1:0] == 2'b11 && nxt_ambient[3:0] > amb_high)
    |=> sub_level == `SUB_CEILING_LEVEL)
    else $error("brightening response did not go to ceiling");

  fade_masked_a: assert property (
    sub_ctrl_ff[0] ##1 sub_ctrl_ff[0] |-> !sub_fade_enable && !sub_fade_initiate)
    else $error("fade reached Sub group while ambient response enabled");

  bias_follows_a: assert property (
    $rose(cfg_a_ff[0]) |=> sensor_bias_output_en)
    else $error("bias regulator not enabled by sensor enable");

  reading_sign_a: assert property (
    meas_done_s |=> ambient_ff[4] == $past(cfg_c_ff[3]))
    else $error("ambient sign bit wrong");

  sub_low_dim_a: assert property (
    meas_done_s and (sub_ctrl_ff[1:0] == 2'b01 && nxt_ambient[3:0] < amb_low
    && nxt_ambient[3:0] <= amb_high) |=> sub_level == `SUB_CEILING_LEVEL)
    else $error("dimming response did not go to ceiling");

  sub_low_bright_a: assert property (
    meas_done_s and (sub_ctrl_ff[1:0] == 2'b11 && nxt_ambient[3:0] < amb_low
    && nxt_ambient[3:0] <= amb_high) |=> sub_level == `SUB_FLOOR_LEVEL)
    else $error("brightening response did not go to floor");

  sub_band_hold_a: assert property (
    meas_done_s and (sub_ctrl_ff[0] && nxt_ambient[3:0] <= amb_high
    && nxt_ambient[3:0] >= amb_low) |=> $stable(sub_level))
    else $error("Sub level moved while reading was between thresholds");

  sub_off_hold_a: assert property (
    !sub_ctrl_ff[`SUB_CTRL_ENABLE] |=> $stable(sub_level))
    else $error("Sub level moved while ambient response disabled");

  gain_step_up_a: assert property (
    meas_done_s and (!cfg_a_ff[3] && !gain_res_high && adc_raw < `AUTO_GAIN_DIM_LIMIT)
    |=> gain_res_high)
    else $error("dim reading did not select the high gain resistor");

  gain_step_down_a: assert property (
    meas_done_s and (!cfg_a_ff[3] && gain_res_high && adc_raw >= `AUTO_GAIN_BRIGHT_LIMIT)
    |=> !gain_res_high)
    else $error("bright reading did not select the low gain resistor");

  bias_copy_a: assert property (
    1'b1 |=> bias_select == $past(cfg_b_ff[`CFG_B_BIAS_SELECT_LSB +: 2]))
    else $error("bias select output does not follow its register field");

  curve_copy_a: assert property (
    1'b1 |=> sensor_linearity == $past(cfg_a_ff[1]) && output_curve == $past(cfg_a_ff[2]))
    else $error("linearity or curve output does not follow its register bit");

  start_pulse_a: assert property (
    conv_start |=> !conv_start)
    else $error("conversion start wider than one cycle");

  manual_start_a: assert property (
    !auto_poll && poll_req_ff && state_ff == ST_IDLE && cfg_a_ff[0] |=> started_s)
    else $error("pending manual request did not start a measurement");

  reading_hold_a: assert property (
    !(state_ff == ST_CONVERT && adc_done) |=> $stable(ambient_ff))
    else $error("ambient reading changed without a finished measurement");
endmodule : ambient_light_control

// ==== dv/sensor_model.sv ====
// Behavioural A/D and light sensor model answering conversion requests
`timescale 1ns/1ns
module sensor_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic conv_start,
  input wire ambient_light_pkg::reg_byte_t raw_in,
  input wire logic [3:0] delay,
  output ambient_light_pkg::reg_byte_t adc_raw,
  output logic adc_done
);
  import ambient_light_pkg::*;
  logic [3:0] cnt_ff;
  logic busy_ff;
  // Code is only valid with done; otherwise it toggles every cycle
  always_ff @(posedge mclk) begin
    adc_done <= 1'b0;
    adc_raw <= ~adc_raw;
    if (reset) begin
      busy_ff <= 1'b0;
      cnt_ff <= 4'h0;
      adc_raw <= 8'h00;
    end else if (conv_start) begin
      busy_ff <= 1'b1;
      cnt_ff <= delay;
    end else if (busy_ff && cnt_ff == 4'h0) begin
      busy_ff <= 1'b0;
      adc_done <= 1'b1;
      adc_raw <= raw_in;
    end else if (busy_ff) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end
endmodule : sensor_model

// ==== dv/tb.sv ====
// Self-checking testbench of the ambient light block
`timescale 1ns/1ns
module tb;
  import ambient_light_pkg::*;
  localparam int UNIT = 20;
  logic mclk, reset, reg_wr, reg_rd, fade_enable, fade_initiate, adc_done, conv_start;
  logic gain_res_high, sensor_bias_output_en, sensor_linearity, output_curve, sub_active;
  logic sub_fade_enable, sub_fade_initiate;
  logic [1:0] bias_select;
  logic [3:0] delay;
  reg_byte_t reg_addr, reg_wdata, reg_rdata, adc_raw, main_level, sub_level, raw_in;
  reg_byte_t lv [16];
  int miscompares = 0, checked = 0, starts = 0, cyc = 0;
  ambient_light_control #(.POLL_UNIT_CYCLES(UNIT)) dut (.mclk(mclk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .adc_raw(adc_raw), .adc_done(adc_done), .conv_start(conv_start),
    .gain_res_high(gain_res_high), .sensor_bias_output_en(sensor_bias_output_en),
    .bias_select(bias_select), .sensor_linearity(sensor_linearity),
    .output_curve(output_curve), .main_level(main_level), .sub_level(sub_level),
    .sub_active(sub_active), .fade_enable(fade_enable), .fade_initiate(fade_initiate),
    .sub_fade_enable(sub_fade_enable), .sub_fade_initiate(sub_fade_initiate));
  sensor_model model (.mclk(mclk), .reset(reset), .conv_start(conv_start), .raw_in(raw_in),
    .delay(delay), .adc_raw(adc_raw), .adc_done(adc_done));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (conv_start === 1'b1) starts <= starts + 1;
  end
  task automatic tally_and_finish;
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input reg_byte_t got, input reg_byte_t exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input reg_byte_t a, input reg_byte_t d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rchk(input reg_byte_t a, input reg_byte_t e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rchk
  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle
  // Manual request, then wait for the conversion and the result update
  task automatic measure(input reg_byte_t raw, input reg_byte_t cfg);
    int n;
    raw_in <= raw;
    wr(8'h10, cfg | 8'h80);
    n = 0;
    while (adc_done !== 1'b1 && n < 60) begin
      @(posedge mclk);
      #1 n++;
    end
    chk({7'h00, adc_done}, 8'h01);
    settle();
  endtask : measure
  task automatic wait_start(output int t);
    int n, s;
    n = 0;
    s = starts;
    while (starts == s && n < 200) begin
      @(posedge mclk);
      #1 n++;
    end
    t = cyc;
  endtask : wait_start
  function automatic reg_byte_t ambient_reading(input reg_byte_t raw, input logic [3:0] g);
    int c;
    c = int'(raw) * (16 + int'($signed(g))) / 16;
    if (c > 255) c = 255;
    return {3'b000, g[3], c[7:4]};
  endfunction : ambient_reading
  task automatic t_reset;
    chk({7'h00, sensor_linearity}, 8'h00);
    chk({7'h00, output_curve}, 8'h00);
    chk(sub_level, 8'h00);
    for (int i = 0; i < 16; i++) rchk(reg_byte_t'(8'h12 + i), lv[i]);
    rchk(8'h0E, 8'h00);
    rchk(8'h22, 8'hC3);
    rchk(8'h23, 8'h00);
    rchk(8'h05, 8'h00);
  endtask : t_reset
  task automatic t_regs;
    wr(8'h12, 8'h2A);
    wr(8'h21, 8'h55);
    lv[0] = 8'h2A;
    lv[15] = 8'h55;
    rchk(8'h12, 8'h2A);
    rchk(8'h21, 8'h55);
    wr(8'h11, 8'hFF);
    rchk(8'h11, 8'h00);
    wr(8'h30, 8'hAB);
    rchk(8'h30, 8'h00);
  endtask : t_regs
  task automatic t_bias;
    for (int b = 0; b < 4; b++) begin
      wr(8'h0F, reg_byte_t'(b));
      settle();
      chk({6'h00, bias_select}, reg_byte_t'(b));
    end
    wr(8'h0E, 8'h07);
    settle();
    chk({5'h00, output_curve, sensor_linearity, sensor_bias_output_en}, 8'h07);
    wr(8'h0E, 8'h00);
    settle();
    chk({7'h00, sensor_bias_output_en}, 8'h00);
  endtask : t_bias
  task automatic t_gain;
    reg_byte_t e;
    wr(8'h0E, 8'h09);
    for (int g = 0; g < 16; g++) begin
      measure(8'hC8, 8'h40 | reg_byte_t'(g));
      e = ambient_reading(8'hC8, 4'(g));
      rchk(8'h11, e);
      chk(main_level, lv[e[3:0]]);
    end
  endtask : t_gain
  task automatic t_autogain;
    int s;
    wr(8'h0E, 8'h01);
    measure(8'h08, 8'h40);
    chk({7'h00, gain_res_high}, 8'h01);
    measure(8'hF8, 8'h40);
    chk({7'h00, gain_res_high}, 8'h00);
    rchk(8'h11, 8'h01);
    wr(8'h0E, 8'h09);
    measure(8'h08, 8'h40);
    chk({7'h00, gain_res_high}, 8'h00);
    s = starts;
    repeat (200) @(posedge mclk);
    chk(reg_byte_t'(starts - s), 8'h00);
  endtask : t_autogain
  task automatic t_poll;
    int t0, t1, d;
    delay <= 4'h1;
    for (int p = 0; p < 4; p++) begin
      wr(8'h10, reg_byte_t'(p << 4));
      wait_start(t0);
      wait_start(t0);
      wait_start(t1);
      d = t1 - t0 - (p + 1) * UNIT;
      chk({7'h00, d >= 0 && d <= 6}, 8'h01);
    end
    wr(8'h10, 8'h40);
    delay <= 4'h6;
    settle();
  endtask : t_poll
  task automatic t_sub;
    wr(8'h0E, 8'h09);
    wr(8'h22, 8'h94);
    rchk(8'h22, 8'h94);
    wr(8'h23, 8'h01);
    settle();
    chk({7'h00, sub_active}, 8'h01);
    measure(8'h20, 8'h40);
    chk(sub_level, 8'h2C);
    measure(8'h60, 8'h40);
    chk(sub_level, 8'h2C);
    measure(8'hC0, 8'h40);
    chk(sub_level, 8'h00);
    wr(8'h23, 8'h03);
    measure(8'hC0, 8'h40);
    chk(sub_level, 8'h2C);
    measure(8'h20, 8'h40);
    chk(sub_level, 8'h00);
    @(posedge mclk);
    fade_enable <= 1'b1;
    fade_initiate <= 1'b1;
    settle();
    chk({6'h00, sub_fade_enable, sub_fade_initiate}, 8'h00);
    wr(8'h23, 8'h00);
    settle();
    chk({6'h00, sub_fade_enable, sub_fade_initiate}, 8'h03);
  endtask : t_sub
  initial begin
    repeat (30000) @(posedge mclk);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    {reset, reg_wr, reg_rd, fade_enable, fade_initiate} = 5'b10000;
    {reg_addr, reg_wdata, raw_in} = 24'h00_0000;
    delay = 4'h6;
    lv = '{8'h04, 8'h05, 8'h06, 8'h08, 8'h0A, 8'h0D, 8'h10, 8'h14,
      8'h19, 8'h1F, 8'h27, 8'h30, 8'h3C, 8'h4A, 8'h5C, 8'h72};
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    settle();
    t_reset();
    t_regs();
    t_bias();
    t_gain();
    t_autogain();
    t_poll();
    t_sub();
    tally_and_finish();
  end
endmodule : tb
